/* src/arh_pkg.sv */
package arh_pkg;

  // ***************************************************
  // Sizes
  // ***************************************************
  localparam int NUM_AXES   = 4;
  localparam int NUM_CTRL   = 4;
  localparam int AX_KINDS   = 4;
  localparam int NUM_LATCH  = NUM_CTRL + NUM_AXES * AX_KINDS;
  localparam int NUM_SLOTS  = NUM_LATCH + NUM_AXES;
  localparam int HIST_DEPTH = 10;
  localparam int NUM_REQ    = 4;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_HZ       = 20_000_000;
  localparam int BLINK_ON_MS  = 200;
  localparam int BLINK_OFF_MS = 200;
  localparam int BLINK_GAP_MS = 1500;
  localparam int BLINK_ON_CYC  = BLINK_ON_MS * (CLK_HZ / 1000);
  localparam int BLINK_OFF_CYC = BLINK_OFF_MS * (CLK_HZ / 1000);
  localparam int BLINK_GAP_CYC = BLINK_GAP_MS * (CLK_HZ / 1000);

  // ***************************************************
  // Register offsets (byte addresses, low byte)
  // ***************************************************
  localparam logic [7:0] OFS_CTRLWORD = 8'h00;
  localparam logic [7:0] OFS_CMD2     = 8'h04;
  localparam logic [7:0] OFS_HCLR     = 8'h08;
  localparam logic [7:0] OFS_FERR_WIN = 8'h0c;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_PRESET   = 8'h1c;
  localparam logic [7:0] OFS_HIST0    = 8'h40;

  // ***************************************************
  // Field positions and reset values
  // ***************************************************
  localparam int CW_FAULT_RST_BIT = 7;
  localparam int CMD2_CLR_BIT     = 0;
  localparam int HCLR_BIT         = 0;
  localparam int ST_CODE_LSB      = 0;
  localparam int ST_BLINK_LSB     = 8;
  localparam int ST_ANY_BIT       = 12;
  localparam int ST_EXC_LSB       = 16;
  localparam int IRQ_NEW_BIT      = 0;
  localparam int IRQ_RESET_BIT    = 1;
  localparam int IRQ_HCLR_BIT     = 2;
  localparam int IRQ_W            = 3;
  localparam logic [31:0] FERR_WIN_RST = 32'h0000_1000;

  // ***************************************************
  // Alarm kinds: ctrl 0..3, axis 4..7, absolute 8
  // ***************************************************
  localparam logic [7:0] KIND_CODE [9] = '{8'h41, 8'h4c, 8'h82, 8'h84,
    8'h10, 8'h20, 8'h21, 8'h22, 8'h33};
  localparam logic [3:0] KIND_BLINK [9] = '{4'h9, 4'h7, 4'h7, 4'h7,
    4'h4, 4'h5, 4'h2, 4'h3, 4'h7};
  localparam logic KIND_PWR [9] = '{1'b1, 1'b1, 1'b0, 1'b1,
    1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  // Blink sequencer states, Gray along the loop
  typedef enum logic [1:0] {
    ARH_BL_IDLE = 2'b00,
    ARH_BL_ON   = 2'b01,
    ARH_BL_OFF  = 2'b11,
    ARH_BL_GAP  = 2'b10
  } arh_blink_st_t;

endpackage

/* src/arh_edge.sv */
`timescale 1ns/100ps
`default_nettype none
module arh_edge import arh_pkg::*; #(
  parameter int W = 4
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Levels in, rising edges out
  input  wire logic [W-1:0] lvl,
  output var  logic [W-1:0] rise
);

  logic [W-1:0] prev_r;
  logic [W-1:0] rise_r;

  // Only a 0-to-1 step makes a pulse; steady levels do nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= '0;
      rise_r <= '0;
    end else if (ce) begin
      prev_r <= lvl;
      rise_r <= lvl & ~prev_r;
    end
  end

  assign rise = rise_r;

endmodule
`default_nettype wire

/* src/arh_blink.sv */
`timescale 1ns/100ps
`default_nettype none
module arh_blink import arh_pkg::*; #(
  parameter int ON_CYC  = BLINK_ON_CYC,
  parameter int OFF_CYC = BLINK_OFF_CYC,
  parameter int GAP_CYC = BLINK_GAP_CYC
) (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Blink count of the alarm shown, 0 for none
  input  wire logic [3:0] blinks,
  output var  logic       led
);

  arh_blink_st_t st_r;
  logic [31:0]   tmr_r;
  logic [3:0]    cnt_r;
  logic [3:0]    num_r;
  logic          led_r;

  // Count latched per sequence so a change to another nonzero count never cuts a burst short
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r  <= ARH_BL_IDLE;
      tmr_r <= '0;
      cnt_r <= '0;
      num_r <= '0;
      led_r <= 1'b0;
    end else if (ce) begin
      unique case (st_r)
        ARH_BL_IDLE: begin
          led_r <= 1'b0;
          if (blinks != 4'h0) begin
            num_r <= blinks;
            cnt_r <= 4'h1;
            tmr_r <= 32'(ON_CYC - 1);
            led_r <= 1'b1;
            st_r  <= ARH_BL_ON;
          end
        end
        ARH_BL_ON: begin
          if (tmr_r == '0) begin
            led_r <= 1'b0;
            tmr_r <= 32'(OFF_CYC - 1);
            st_r  <= ARH_BL_OFF;
          end else begin
            tmr_r <= tmr_r - 32'h1;
          end
        end
        ARH_BL_OFF: begin
          if (tmr_r != '0) begin
            tmr_r <= tmr_r - 32'h1;
          end else if (cnt_r == num_r) begin
            tmr_r <= 32'(GAP_CYC - 1);
            st_r  <= ARH_BL_GAP;
          end else begin
            cnt_r <= cnt_r + 4'h1;
            led_r <= 1'b1;
            tmr_r <= 32'(ON_CYC - 1);
            st_r  <= ARH_BL_ON;
          end
        end
        ARH_BL_GAP: begin
          if (tmr_r == '0) begin
            st_r <= ARH_BL_IDLE;
          end else begin
            tmr_r <= tmr_r - 32'h1;
          end
        end
      endcase
      // Alarm gone: cut the burst so the lamp never outlives the alarm
      if (blinks == 4'h0) begin
        st_r  <= ARH_BL_IDLE;
        led_r <= 1'b0;
      end
    end
  end

  assign led = led_r;

endmodule
`default_nettype wire

/* src/arh_alarm_core.sv */
`timescale 1ns/100ps
`default_nettype none
module arh_alarm_core import arh_pkg::*; #(
  parameter int ON_CYC  = BLINK_ON_CYC,
  parameter int OFF_CYC = BLINK_OFF_CYC,
  parameter int GAP_CYC = BLINK_GAP_CYC
) (
  // Clock, power-on reset, clock enable, storage init
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  nv_rst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output var  logic [31:0]           hrdata,
  output var  logic                  hreadyout,
  output var  logic                  hresp,
  // Fault detectors
  input  wire logic [NUM_CTRL-1:0]   ctrl_fault,
  input  wire logic [NUM_AXES-1:0]   axis_short,
  input  wire logic [NUM_AXES-1:0]   axis_overtemp,
  input  wire logic [NUM_AXES-1:0]   axis_overvolt,
  input  wire logic [NUM_AXES-1:0]   axis_abs_err,
  input  wire logic [NUM_AXES-1:0]   axis_current_on,
  input  wire logic [NUM_AXES*32-1:0] axis_dev_mag,
  // Discrete reset input
  input  wire logic                  alarm_clear_input,
  // Alarm outputs
  output var  logic                  alarm_out_active_on,
  output var  logic                  alarm_out_active_off,
  output var  logic                  motor_stop,
  output var  logic [NUM_AXES-1:0]   axis_excite_off,
  output var  logic                  led_red,
  output var  logic                  irq
);

  // ***************************************************
  // Declarations
  // ***************************************************
  logic [15:0]           cw_r;
  logic [15:0]           cmd2_r;
  logic                  hclr_r;
  logic [31:0]           ferr_win_r;
  logic [IRQ_W-1:0]      stat_r;
  logic [IRQ_W-1:0]      mask_r;
  logic                  irq_r;
  logic [NUM_LATCH-1:0]  act_r;
  logic [NUM_AXES-1:0]   abs_r;
  logic [NUM_AXES-1:0]   preset_r;
  logic [7:0]            hist_r [HIST_DEPTH];
  logic [31:0]           hrdata_r;
  logic                  wr_pend_r;
  logic [7:0]            wr_ofs_r;
  logic                  on_r;
  logic                  off_r;
  logic                  stop_r;
  logic [NUM_AXES-1:0]   exc_off_r;

  logic [NUM_LATCH-1:0]  set_lat;
  logic [NUM_LATCH-1:0]  act_nxt;
  logic [NUM_SLOTS-1:0]  set_all;
  logic [NUM_SLOTS-1:0]  act_all;
  logic [NUM_SLOTS-1:0]  new_vec;
  logic [NUM_SLOTS-1:0]  pwr_vec;
  logic [7:0]            slot_code [NUM_SLOTS];
  logic [3:0]            slot_blink [NUM_SLOTS];
  logic [NUM_AXES-1:0]   dev_hit;
  logic [NUM_AXES-1:0]   axis_any;
  logic [NUM_REQ-1:0]    req_lvl;
  logic [NUM_REQ-1:0]    req_rise;
  logic                  rst_any;
  logic                  hist_wipe;
  logic                  new_any;
  logic [4:0]            new_idx;
  logic [4:0]            disp_idx;
  logic                  any_act;
  logic [3:0]            disp_blinks;
  logic [IRQ_W-1:0]      ev_vec;
  logic [IRQ_W-1:0]      w1c_vec;
  logic [IRQ_W-1:0]      stat_nxt;
  logic [31:0]           status_word;
  logic                  acc;
  logic [7:0]            rd_ofs;
  logic [7:0]            hist_off;
  logic [3:0]            hist_idx;
  logic                  hist_hit;
  logic [31:0]           rd_word;
  logic                  wr_now;
  logic                  wr_cw;
  logic                  wr_cmd2;
  logic                  wr_hclr;
  logic                  wr_ferr;
  logic                  wr_stat;
  logic                  wr_mask;
  logic                  wr_preset;

  // Lowest set index wins; ctrl slots first, then axis kinds by axis, absolute slots last
  function automatic logic [4:0] first_idx(input logic [NUM_SLOTS-1:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // ***************************************************
  // Alarm sources and tables
  // ***************************************************
  assign set_lat[NUM_CTRL-1:0] = ctrl_fault;

  // One generate per axis: four latched kinds and the detector hookup
  for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
    localparam int B = NUM_CTRL + a * AX_KINDS;
    assign dev_hit[a] = axis_current_on[a]
                        & (axis_dev_mag[a*32 +: 32] > ferr_win_r);
    assign set_lat[B]   = dev_hit[a];
    assign set_lat[B+1] = axis_short[a];
    assign set_lat[B+2] = axis_overtemp[a];
    assign set_lat[B+3] = axis_overvolt[a];
    assign axis_any[a]  = (|act_r[B +: AX_KINDS]) | abs_r[a];
  end

  // Kind of every slot picks its code, blink count and reset class
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    localparam int K = (s < NUM_CTRL) ? s :
                       (s < NUM_LATCH) ? NUM_CTRL + (s - NUM_CTRL) % AX_KINDS :
                       NUM_CTRL + AX_KINDS;
    assign slot_code[s]  = KIND_CODE[K];
    assign slot_blink[s] = KIND_BLINK[K];
    assign pwr_vec[s]    = KIND_PWR[K];
  end

  assign set_all = {axis_abs_err, set_lat};
  assign act_all = {abs_r, act_r};
  assign new_vec = set_all & ~act_all;
  assign new_any = |new_vec;
  assign new_idx = first_idx(new_vec);
  assign any_act = |act_all;
  assign disp_idx = first_idx(act_all);
  assign disp_blinks = any_act ? slot_blink[disp_idx] : 4'h0;

  // ***************************************************
  // Reset requests
  // ***************************************************
  assign req_lvl = {hclr_r, alarm_clear_input, cmd2_r[CMD2_CLR_BIT],
                    cw_r[CW_FAULT_RST_BIT]};

  arh_edge #(
    .W (NUM_REQ)
  ) u_edge (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .lvl  (req_lvl),
    .rise (req_rise)
  );

  assign rst_any   = |req_rise[2:0];
  assign hist_wipe = req_rise[3];

  // A new fault wins over a reset in the same cycle; power-cycle kinds stay
  assign act_nxt = set_lat
                 | (act_r & ~({NUM_LATCH{rst_any}} & ~pwr_vec[NUM_LATCH-1:0]));

  // Latched alarms; a power-on reset is the power cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      act_r <= '0;
    end else if (ce) begin
      act_r <= act_nxt;
    end
  end

  // Absolute alarm survives power-on reset unless a preset was done
  always_ff @(posedge clk) begin
    if (nv_rst) begin
      abs_r    <= '0;
      preset_r <= '0;
    end else if (rst) begin
      abs_r    <= abs_r & ~preset_r;
      preset_r <= '0;
    end else if (ce) begin
      abs_r    <= abs_r | axis_abs_err;
      preset_r <= preset_r
                | (wr_preset ? hwdata[NUM_AXES-1:0] : '0);
    end
  end

  // ***************************************************
  // History, kept across power-on reset
  // ***************************************************
  // Wipe first, then a new alarm in the same cycle lands at entry 0
  for (genvar h = 0; h < HIST_DEPTH; h++) begin : g_hist
    always_ff @(posedge clk) begin
      if (nv_rst) begin
        hist_r[h] <= '0;
      end else if (ce && (hist_wipe || new_any)) begin
        if (h == 0) begin
          hist_r[h] <= new_any ? slot_code[new_idx] : 8'h00;
        end else begin
          hist_r[h] <= (hist_wipe || !new_any) ? 8'h00 : hist_r[(h == 0) ? 0 : h - 1];
        end
      end
    end
  end

  // ***************************************************
  // Outputs to the drive
  // ***************************************************
  // All registered so nothing glitches onto the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      on_r      <= 1'b0;
      off_r     <= 1'b1;
      stop_r    <= 1'b0;
      exc_off_r <= '0;
    end else if (ce) begin
      on_r      <= any_act;
      off_r     <= ~any_act;
      stop_r    <= any_act;
      exc_off_r <= axis_any;
    end
  end

  arh_blink #(
    .ON_CYC  (ON_CYC),
    .OFF_CYC (OFF_CYC),
    .GAP_CYC (GAP_CYC)
  ) u_blink (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .blinks (disp_blinks),
    .led    (led_red)
  );

  // ***************************************************
  // Bus decode
  // ***************************************************
  assign acc      = hsel & hready & htrans[1];
  assign rd_ofs   = haddr[7:0];
  assign hist_off = rd_ofs - OFS_HIST0;
  assign hist_idx = hist_off[5:2];
  assign hist_hit = (rd_ofs >= OFS_HIST0) && (hist_idx < 4'(HIST_DEPTH))
                    && (hist_off[1:0] == 2'b00);

  assign status_word = (32'(slot_code[disp_idx] & {8{any_act}}) << ST_CODE_LSB)
                     | (32'(disp_blinks) << ST_BLINK_LSB)
                     | (32'(any_act) << ST_ANY_BIT)
                     | (32'(axis_any) << ST_EXC_LSB);

  // Unmapped offsets read zero, except 0x80-0xA4 and 0xC0-0xE4 which alias the history; all answer OKAY
  assign rd_word = hist_hit                 ? 32'(hist_r[hist_idx]) :
                   (rd_ofs == OFS_CTRLWORD) ? 32'(cw_r) :
                   (rd_ofs == OFS_CMD2)     ? 32'(cmd2_r) :
                   (rd_ofs == OFS_HCLR)     ? 32'(hclr_r) :
                   (rd_ofs == OFS_FERR_WIN) ? ferr_win_r :
                   (rd_ofs == OFS_STATUS)   ? status_word :
                   (rd_ofs == OFS_IRQ_STAT) ? 32'(stat_r) :
                   (rd_ofs == OFS_IRQ_MASK) ? 32'(mask_r) :
                   (rd_ofs == OFS_PRESET)   ? 32'(preset_r) : 32'h0000_0000;

  assign wr_now    = wr_pend_r & ce;
  assign wr_cw     = wr_now && (wr_ofs_r == OFS_CTRLWORD);
  assign wr_cmd2   = wr_now && (wr_ofs_r == OFS_CMD2);
  assign wr_hclr   = wr_now && (wr_ofs_r == OFS_HCLR);
  assign wr_ferr   = wr_now && (wr_ofs_r == OFS_FERR_WIN);
  assign wr_stat   = wr_now && (wr_ofs_r == OFS_IRQ_STAT);
  assign wr_mask   = wr_now && (wr_ofs_r == OFS_IRQ_MASK);
  assign wr_preset = wr_now && (wr_ofs_r == OFS_PRESET);

  // ***************************************************
  // Bus phases
  // ***************************************************
  // Zero wait: read data is fetched in the address phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata_r  <= '0;
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= '0;
    end else if (ce) begin
      wr_pend_r <= acc & hwrite;
      wr_ofs_r  <= rd_ofs;
      if (acc && !hwrite) begin
        hrdata_r <= rd_word;
      end
    end
  end

  // Software-written objects
  always_ff @(posedge clk) begin
    if (rst) begin
      cw_r       <= '0;
      cmd2_r     <= '0;
      hclr_r     <= 1'b0;
      ferr_win_r <= FERR_WIN_RST;
      mask_r     <= '0;
    end else begin
      if (wr_cw)   cw_r       <= hwdata[15:0];
      if (wr_cmd2) cmd2_r     <= hwdata[15:0];
      if (wr_hclr) hclr_r     <= hwdata[HCLR_BIT];
      if (wr_ferr) ferr_win_r <= hwdata;
      if (wr_mask) mask_r     <= hwdata[IRQ_W-1:0];
    end
  end

  // ***************************************************
  // Interrupts
  // ***************************************************
  assign ev_vec   = (IRQ_W'(new_any) << IRQ_NEW_BIT)
                  | (IRQ_W'(rst_any) << IRQ_RESET_BIT)
                  | (IRQ_W'(hist_wipe) << IRQ_HCLR_BIT);
  assign w1c_vec  = wr_stat ? hwdata[IRQ_W-1:0] : '0;
  assign stat_nxt = ev_vec | (stat_r & ~w1c_vec);                 // Set beats clear

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_r <= '0;
      irq_r  <= 1'b0;
    end else if (ce) begin
      stat_r <= stat_nxt;
      irq_r  <= |(stat_nxt & mask_r);
    end
  end

  assign hrdata               = hrdata_r;
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign alarm_out_active_on  = on_r;
  assign alarm_out_active_off = off_r;
  assign motor_stop           = stop_r;
  assign axis_excite_off      = exc_off_r;
  assign irq                  = irq_r;

endmodule
`default_nettype wire

/* verification/arh_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module arh_host_model (
  // Clock
  input  wire logic clk,
  // Discrete clear line
  output var  logic alarm_clear_input
);
  initial alarm_clear_input = 1'b0;
  // Level stays put between calls; only a low-to-high step clears
  task automatic drive(input logic v);
    @(posedge clk);
    alarm_clear_input <= v;
  endtask
endmodule
`default_nettype wire

/* verification/arh_alarm_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module arh_alarm_monitor import arh_pkg::*; #(
  parameter int ON_CYC  = BLINK_ON_CYC,
  parameter int OFF_CYC = BLINK_OFF_CYC,
  parameter int GAP_CYC = BLINK_GAP_CYC
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Bus answer
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  // Fault inputs
  input wire logic [NUM_CTRL-1:0]     ctrl_fault,
  input wire logic [NUM_AXES-1:0]     axis_short,
  input wire logic [NUM_AXES-1:0]     axis_overtemp,
  input wire logic [NUM_AXES-1:0]     axis_overvolt,
  input wire logic [NUM_AXES-1:0]     axis_abs_err,
  input wire logic [NUM_AXES-1:0]     axis_current_on,
  input wire logic [NUM_AXES*32-1:0]  axis_dev_mag,
  // Alarm outputs
  input wire logic                    alarm_out_active_on,
  input wire logic                    alarm_out_active_off,
  input wire logic                    motor_stop,
  input wire logic [NUM_AXES-1:0]     axis_excite_off,
  input wire logic                    led_red
);
  // ***************************************************
  // Helpers
  // ***************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [3:0] ax_flt  = axis_short | axis_overtemp | axis_overvolt | axis_abs_err;
  wire logic       pwr_flt = ctrl_fault[0] | ctrl_fault[1] | ctrl_fault[3] | (|axis_short);
  logic [7:0]      hi_cnt;
  // Length of the current lit stretch; wide enough for short sim counts only
  always_ff @(posedge clk) begin
    hi_cnt <= (rst || !led_red) ? 8'h00 : hi_cnt + 8'h01;
  end
  sequence dark_run;
    !led_red [*4];
  endsequence
  // ***************************************************
  // Assertions
  // ***************************************************
  onoff_pair_a: assert property (alarm_out_active_off == !alarm_out_active_on)
    else $error("alarm outputs not complementary");
  stop_follow_a: assert property (motor_stop == alarm_out_active_on)
    else $error("motor stop differs from alarm");
  excite_drop_a: assert property (ax_flt != 4'h0 |=> ##1
    (axis_excite_off & $past(ax_flt, 2)) == $past(ax_flt, 2)) else $error("axis still excited");
  dev_trip_a: assert property (axis_current_on[3] && axis_dev_mag[127:96] > FERR_WIN_RST
    |=> ##1 axis_excite_off[3]) else $error("deviation alarm missed");
  pwr_hold_a: assert property (pwr_flt |=> ##1 alarm_out_active_on [*8])
    else $error("power cycle alarm dropped");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  led_quiet_a: assert property (!alarm_out_active_on [*3] |-> !led_red)
    else $error("led lit without alarm");
  blink_width_a: assert property ($fell(led_red) && ctrl_fault[0] |-> hi_cnt == ON_CYC)
    else $error("blink width wrong");
  blink_gap_a: assert property ($fell(led_red) && ctrl_fault[0] |-> dark_run)
    else $error("blink dark time short");
endmodule
bind arh_alarm_core arh_alarm_monitor #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC), .GAP_CYC(GAP_CYC))
  i_arh_alarm_monitor (.clk, .rst, .hreadyout, .hresp, .ctrl_fault, .axis_short,
  .axis_overtemp, .axis_overvolt, .axis_abs_err, .axis_current_on, .axis_dev_mag,
  .alarm_out_active_on, .alarm_out_active_off, .motor_stop, .axis_excite_off, .led_red);
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench import arh_pkg::*;;
  // ***************************************************
  // Signals and instances
  // ***************************************************
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         nv_rst = 1'b1;
  logic         ce = 1'b1;
  logic         hsel = 1'b0;
  logic         hwrite = 1'b0;
  logic [1:0]   htrans = 2'h0;
  logic [2:0]   hsize = 3'h2;
  logic [31:0]  haddr = 32'h0;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata, rd;
  logic [3:0]   flt [5] = '{default: 4'h0};
  logic [3:0]   axis_current_on = 4'h0;
  logic [127:0] axis_dev_mag = 128'h0;
  logic         hreadyout, hresp, alarm_clear_input, on, off, stop, led_red, irq;
  logic [3:0]   exc;
  logic [7:0]   hq [$];
  int           error_cnt = 0;
  int           tests_run = 0;
  // Alarm table: code, fault group, bit, blinks; first three resettable
  localparam logic [7:0] TC [7] = '{8'h21, 8'h82, 8'h22, 8'h41, 8'h4c, 8'h84, 8'h20};
  localparam int         TK [7] = '{2, 0, 3, 0, 0, 0, 1};
  localparam int         TB [7] = '{0, 2, 1, 0, 1, 3, 3};
  localparam logic [3:0] TN [7] = '{4'h2, 4'h7, 4'h3, 4'h9, 4'h7, 4'h7, 4'h5};
  arh_host_model i_arh_host_model (.clk, .alarm_clear_input);
  // Short blink counts keep a full burst, nine blinks and the gap, within 83 cycles
  arh_alarm_core #(.ON_CYC(4), .OFF_CYC(4), .GAP_CYC(10)) i_arh_alarm_core (
    .clk, .rst, .ce, .nv_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ctrl_fault(flt[0]),
    .axis_short(flt[1]), .axis_overtemp(flt[2]), .axis_overvolt(flt[3]),
    .axis_abs_err(flt[4]), .axis_current_on, .axis_dev_mag, .alarm_clear_input,
    .alarm_out_active_on(on), .alarm_out_active_off(off), .motor_stop(stop),
    .axis_excite_off(exc), .led_red, .irq);
  initial begin
    forever #25 clk = ~clk;
  end
  // ***************************************************
  // Tasks
  // ***************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Settle past the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wt;
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // One-cycle fault (or longer hold), noting the expected history entry
  task automatic pul(input int k, input int b, input logic [7:0] c, input int h);
    @(posedge clk);
    flt[k][b] <= 1'b1;
    repeat (h) @(posedge clk);
    flt[k][b] <= 1'b0;
    hq.push_front(c);
    if (hq.size() > 10) hq.pop_back();
    cyc(4);
  endtask
  // Clear paths: 0 discrete line, 1 control word, 2 command word
  task automatic clr(input int m);
    case (m)
      0: begin
        i_arh_host_model.drive(1'b1);
        i_arh_host_model.drive(1'b0);
      end
      1: begin
        xfer(1'b1, OFS_CTRLWORD, 32'h0);
        xfer(1'b1, OFS_CTRLWORD, 32'h80);
      end
      default: begin
        xfer(1'b1, OFS_CMD2, 32'h0);
        xfer(1'b1, OFS_CMD2, 32'h1);
      end
    endcase
    cyc(4);
  endtask
  task automatic prst;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
  endtask
  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    nv_rst <= 1'b0;
    cyc(1);
    chk(off, 1'b1);
    rdc(OFS_FERR_WIN, FERR_WIN_RST);
    rdc(OFS_HIST0, 32'h0);
    rdc(32'h30, 32'h0);
    $display("end reset state");
    for (int i = 0; i < 7; i++) begin
      pul(TK[i], TB[i], TC[i], i == 3 ? 40 : 1);
      chk(stop, 1'b1);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk(rd[12:0], {1'b1, TN[i], TC[i]});
      clr(i % 3);
      chk(on, i > 2);
      if (i > 2) prst;
      chk(on, 1'b0);
    end
    $display("end alarm table");
    i_arh_host_model.drive(1'b1);
    pul(2, 1, 8'h21, 1);
    i_arh_host_model.drive(1'b0);
    cyc(4);
    chk(on, 1'b1);
    xfer(1'b1, OFS_CTRLWORD, 32'h80);
    pul(3, 2, 8'h22, 1);
    xfer(1'b1, OFS_CTRLWORD, 32'h80);
    cyc(4);
    chk(on, 1'b1);
    clr(1);
    chk(on, 1'b0);
    $display("end steady levels");
    @(posedge clk);
    axis_current_on <= 4'h8;
    axis_dev_mag[127:96] <= FERR_WIN_RST;
    cyc(4);
    chk(on, 1'b0);
    @(posedge clk);
    axis_dev_mag[127:96] <= FERR_WIN_RST + 32'h1;
    @(posedge clk);
    axis_dev_mag[127:96] <= FERR_WIN_RST;
    hq.push_front(8'h10);
    cyc(4);
    chk(exc, 4'h8);
    clr(2);
    chk(on, 1'b0);
    pul(4, 1, 8'h33, 1);
    prst;
    chk(on, 1'b1);
    xfer(1'b1, OFS_PRESET, 32'h2);
    prst;
    chk(on, 1'b0);
    $display("end deviation and preset");
    // Enable low: a fault must not latch while frozen
    @(posedge clk);
    ce <= 1'b0;
    flt[0][2] <= 1'b1;
    cyc(3);
    chk(on, 1'b0);
    @(posedge clk);
    flt[0][2] <= 1'b0;
    ce <= 1'b1;
    cyc(3);
    chk(on, 1'b0);
    $display("end clock enable");
    xfer(1'b1, OFS_IRQ_MASK, 32'h1);
    xfer(1'b1, OFS_IRQ_STAT, 32'h7);
    cyc(2);
    chk(irq, 1'b0);
    pul(3, 0, 8'h22, 1);
    chk(irq, 1'b1);
    xfer(1'b1, OFS_IRQ_STAT, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    clr(2);
    for (int i = 0; i < 10; i++) begin
      xfer(1'b0, 32'(OFS_HIST0) + 32'(4 * i), 32'h0);
      chk(rd[7:0], hq[i]);
    end
    xfer(1'b1, OFS_HCLR, 32'h1);
    cyc(2);
    rdc(OFS_HIST0, 32'h0);
    pul(2, 3, 8'h21, 1);
    xfer(1'b1, OFS_HCLR, 32'h1);
    xfer(1'b0, OFS_HIST0, 32'h0);
    chk(rd[7:0], 8'h21);
    $display("end interrupt and history");
    tally_and_finish;
  end
endmodule
`default_nettype wire
